// ---- pkg/srs_pkg.sv ----
// Constants, types and register map of the system reset sequencer
package srs_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS_OFF = 8'h04;
    localparam logic [7:0] REG_MODE_OFF   = 8'h08;
    localparam logic [7:0] REG_MASK_OFF   = 8'h0c;

    // Status and mask field positions (same layout)
    localparam int STS_SEEN_BIT  = 0;
    localparam int STS_TYPE_LSB  = 8;
    localparam int STS_LEVEL_BIT = 16;

    // Mode field positions
    localparam int MODE_UEN_BIT = 0;
    localparam int MODE_IEN_BIT = 4;
    localparam int MODE_LEN_LSB = 8;

    localparam int LEN_W   = 4;
    localparam int TYPE_W  = 3;
    localparam int CNT_W   = 9;
    localparam int PULSE_W = 17;

    // Last reset type codes
    localparam logic [TYPE_W-1:0] RST_TYPE_GENERAL = 3'h0;
    localparam logic [TYPE_W-1:0] RST_TYPE_WAKEUP  = 3'h1;
    localparam logic [TYPE_W-1:0] RST_TYPE_USER    = 3'h4;

    // Timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int STARTUP_TIME_NS = 1280;
    localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES     = 3;
    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST    = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE      = 9'h001;
    localparam logic [1:0]       BOOT_DELAY   = 2'h3;
    localparam logic [PULSE_W-1:0] PULSE_ONE  = 17'h00001;

    // Sequencer states
    typedef enum logic [5:0] {
        ST_BACKUP    = 6'h01,
        ST_STARTUP   = 6'h02,
        ST_HOLD      = 6'h04,
        ST_RUN       = 6'h08,
        ST_CORE_DOWN = 6'h10,
        ST_USER      = 6'h20
    } srs_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } srs_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } srs_apb_rsp_t;

    typedef struct packed {
        logic proc_rst_n;
        logic periph_rst_n;
        logic backup_rst_n;
        logic proc_clk_en;
    } srs_resets_t;

    typedef struct packed {
        logic             user_reset_enable;
        logic             user_reset_irq_enable;
        logic [LEN_W-1:0] pin_pulse_length_field;
    } srs_mode_t;

endpackage : srs_pkg

// ---- design/srs_reset_sequencer.sv ----
// System reset sequencer: power-up sequencing, reset pin manager, boot select, APB registers
`timescale 1ns/1ps

module srs_reset_sequencer (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register bus
    input  wire srs_pkg::srs_apb_req_t apb_req,
    output srs_pkg::srs_apb_rsp_t     apb_rsp,
    // Supply monitors
    input  wire logic                 por_backup_n,
    input  wire logic                 por_core_n,
    // External reset pin
    input  wire logic                 rst_pin_i,
    output logic                      rst_pin_o,
    output logic                      rst_pin_oe_n,
    // Boot select
    input  wire logic                 boot_select_pin,
    output logic                      boot_sel,
    // Resets and interrupt
    output srs_pkg::srs_resets_t      resets,
    output logic                      irq
);
    import srs_pkg::*;

    srs_state_t          state_ff;
    srs_state_t          nxt_state;
    logic [CNT_W-1:0]    cnt_ff;
    logic [CNT_W-1:0]    nxt_cnt;
    logic [TYPE_W-1:0]   pend_type_ff;
    logic [TYPE_W-1:0]   nxt_pend_type;
    logic [TYPE_W-1:0]   type_ff;
    srs_resets_t         resets_ff;
    srs_resets_t         nxt_resets;
    srs_mode_t           mode_ff;
    logic                mask_seen_ff;
    logic                seen_ff;
    logic                nxt_seen;
    logic                irq_ff;
    logic                pin_meta_ff;
    logic                pin_sync_ff;
    logic                pin_prev_ff;
    logic [2:0]          drive_hist_ff;
    logic                drive_ff;
    logic                pulse_on_ff;
    logic [PULSE_W-1:0]  pulse_cnt_ff;
    logic                nxt_pulse_on;
    logic [PULSE_W-1:0]  nxt_pulse_cnt;
    logic                core_prev_ff;
    logic [1:0]          boot_cnt_ff;
    logic                boot_sel_ff;
    srs_apb_rsp_t        rsp_ff;
    logic [31:0]         status_word;
    logic [31:0]         mode_word;
    logic [31:0]         mask_word;

    // Pin input conditioning
    wire pin_low    = ~pin_sync_ff;
    wire pin_fall   = pin_prev_ff & ~pin_sync_ff;
    wire self_quiet = ~drive_ff & (drive_hist_ff == 3'h0);
    wire user_trig  = pin_low & self_quiet & mode_ff.user_reset_enable;

    // Bus decode
    wire setup       = apb_req.psel & ~apb_req.penable;
    wire access_done = apb_req.psel & apb_req.penable & rsp_ff.pready;
    wire hit_status  = (apb_req.paddr == REG_STATUS_OFF);
    wire hit_mode    = (apb_req.paddr == REG_MODE_OFF);
    wire hit_mask    = (apb_req.paddr == REG_MASK_OFF);
    wire mapped      = hit_status | hit_mode | hit_mask;
    wire write_mode  = access_done & apb_req.pwrite & hit_mode;
    wire write_mask  = access_done & apb_req.pwrite & hit_mask;
    wire status_read = access_done & ~apb_req.pwrite & hit_status;
    wire [31:0] rd_mux = hit_status ? status_word :
                         hit_mode   ? mode_word   :
                         hit_mask   ? mask_word   : 32'h0000_0000;

    // Sequencer events
    wire enter_run = (nxt_state == ST_RUN) & (state_ff != ST_RUN);
    wire enter_usr = (nxt_state == ST_USER) & (state_ff == ST_RUN);
    wire ext_req   = (enter_run & (pend_type_ff != RST_TYPE_USER)) | enter_usr;
    // Pin held low through power-up, core-down and non-user hold
    wire hold_pin  = (nxt_state == ST_BACKUP) | (nxt_state == ST_STARTUP) |
                     (nxt_state == ST_CORE_DOWN) |
                     ((nxt_state == ST_HOLD) & (nxt_pend_type != RST_TYPE_USER));
    // Fifth bit keeps a length of 15 from wrapping the shift to zero
    wire [LEN_W:0]     pulse_shift = {1'b0, mode_ff.pin_pulse_length_field} + 5'h01;
    wire [PULSE_W-1:0] pulse_last  = (PULSE_ONE << pulse_shift) - PULSE_ONE;
    wire core_rise = por_core_n & ~core_prev_ff;

    // Register words
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STS_SEEN_BIT] = seen_ff;
        status_word[STS_TYPE_LSB +: TYPE_W] = type_ff;
        status_word[STS_LEVEL_BIT] = pin_sync_ff;
        mode_word = 32'h0000_0000;
        mode_word[MODE_UEN_BIT] = mode_ff.user_reset_enable;
        mode_word[MODE_IEN_BIT] = mode_ff.user_reset_irq_enable;
        mode_word[MODE_LEN_LSB +: LEN_W] = mode_ff.pin_pulse_length_field;
        mask_word = 32'h0000_0000;
        mask_word[STS_SEEN_BIT] = mask_seen_ff;
    end

    // Reset state manager
    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_pend_type = pend_type_ff;
        case (state_ff)
            ST_BACKUP: begin
                if (por_backup_n) begin
                    nxt_state = ST_STARTUP;
                    nxt_cnt   = '0;
                end
            end
            ST_STARTUP: begin
                if (cnt_ff == STARTUP_LAST) begin
                    nxt_state     = ST_HOLD;
                    nxt_cnt       = '0;
                    nxt_pend_type = RST_TYPE_GENERAL;
                end else begin
                    nxt_cnt = cnt_ff + CNT_ONE;
                end
            end
            ST_HOLD: begin
                if (cnt_ff == HOLD_LAST) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_cnt = cnt_ff + CNT_ONE;
                end
            end
            ST_CORE_DOWN: begin
                if (por_core_n) begin
                    nxt_state     = ST_HOLD;
                    nxt_cnt       = '0;
                    nxt_pend_type = RST_TYPE_WAKEUP;
                end
            end
            ST_RUN: begin
                if (user_trig) begin
                    nxt_state = ST_USER;
                end
            end
            ST_USER: begin
                // Internal resets stay while anyone holds the pin low
                if (!pin_low && !pulse_on_ff) begin
                    nxt_state     = ST_HOLD;
                    nxt_cnt       = '0;
                    nxt_pend_type = RST_TYPE_USER;
                end
            end
            default: begin
                nxt_state = ST_BACKUP;
            end
        endcase
        if (resets_ff.backup_rst_n && !por_core_n && state_ff != ST_CORE_DOWN) begin
            nxt_state = ST_CORE_DOWN;
        end
        if (!por_backup_n) begin
            nxt_state = ST_BACKUP;
        end
    end

    // Reset outputs follow the next state
    always_comb begin
        nxt_resets.proc_rst_n   = (nxt_state == ST_RUN);
        nxt_resets.periph_rst_n = (nxt_state == ST_RUN);
        nxt_resets.backup_rst_n = ~((nxt_state == ST_BACKUP) | (nxt_state == ST_STARTUP)) &
                                  (resets_ff.backup_rst_n | (nxt_state == ST_RUN));
        nxt_resets.proc_clk_en  = (nxt_state == ST_HOLD) | (nxt_state == ST_RUN);
    end

    // Pin pulse shaper
    always_comb begin
        nxt_pulse_on  = pulse_on_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        if (nxt_state == ST_BACKUP) begin
            nxt_pulse_on  = 1'b0;
            nxt_pulse_cnt = '0;
        end else if (ext_req) begin
            nxt_pulse_on  = 1'b1;
            nxt_pulse_cnt = pulse_last;
        end else if (pulse_on_ff) begin
            if (pulse_cnt_ff == '0) begin
                nxt_pulse_on = 1'b0;
            end else begin
                nxt_pulse_cnt = pulse_cnt_ff - PULSE_ONE;
            end
        end
    end

    // Seen flag: a new assertion wins over the read clear
    assign nxt_seen = pin_fall | (seen_ff & ~status_read);

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= ST_BACKUP;
            cnt_ff       <= '0;
            pend_type_ff <= RST_TYPE_GENERAL;
            resets_ff    <= '0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            pend_type_ff <= nxt_pend_type;
            resets_ff    <= nxt_resets;
        end
    end

    // Last reset type, loaded only at processor release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            type_ff <= RST_TYPE_GENERAL;
        end else if (enter_run) begin
            type_ff <= pend_type_ff;
        end
    end

    // Pin synchronizer and drive history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff   <= 1'b1;
            pin_sync_ff   <= 1'b1;
            pin_prev_ff   <= 1'b1;
            drive_hist_ff <= 3'h0;
        end else begin
            pin_meta_ff   <= rst_pin_i;
            pin_sync_ff   <= pin_meta_ff;
            pin_prev_ff   <= pin_sync_ff;
            drive_hist_ff <= {drive_hist_ff[1:0], drive_ff};
        end
    end

    // Pin drive: power-up hold, then the shaped pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_on_ff  <= 1'b0;
            pulse_cnt_ff <= '0;
            drive_ff     <= 1'b1;
        end else begin
            pulse_on_ff  <= nxt_pulse_on;
            pulse_cnt_ff <= nxt_pulse_cnt;
            drive_ff     <= hold_pin | nxt_pulse_on;
        end
    end

    // Mode register, backup domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= '0;
        end else if (!resets_ff.backup_rst_n) begin
            mode_ff <= '0;
        end else if (write_mode) begin
            mode_ff.user_reset_enable      <= apb_req.pwdata[MODE_UEN_BIT];
            mode_ff.user_reset_irq_enable  <= apb_req.pwdata[MODE_IEN_BIT];
            mode_ff.pin_pulse_length_field <= apb_req.pwdata[MODE_LEN_LSB +: LEN_W];
        end
    end

    // Mask register: gates the seen flag onto irq
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_seen_ff <= 1'b0;
        end else if (write_mask) begin
            mask_seen_ff <= apb_req.pwdata[STS_SEEN_BIT];
        end
    end

    // Status flag and interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end else begin
            seen_ff <= nxt_seen;
            irq_ff  <= nxt_seen & mask_seen_ff & mode_ff.user_reset_irq_enable &
                       ~mode_ff.user_reset_enable;
        end
    end

    // Boot select sampling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_prev_ff <= 1'b0;
            boot_cnt_ff  <= 2'h0;
            boot_sel_ff  <= 1'b0;
        end else begin
            core_prev_ff <= por_core_n;
            if (core_rise) begin
                boot_cnt_ff <= BOOT_DELAY;
            end else if (boot_cnt_ff != 2'h0) begin
                boot_cnt_ff <= boot_cnt_ff - 2'h1;
            end
            if (boot_cnt_ff == 2'h1) begin
                boot_sel_ff <= boot_select_pin;
            end
        end
    end

    // APB answer: data captured in setup, ready in the access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.pready  <= setup;
            rsp_ff.pslverr <= setup & ~mapped;
            rsp_ff.prdata  <= (setup & ~apb_req.pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Outputs straight from registers, rst_pin_o tied low; the pin is open drain
    assign apb_rsp      = rsp_ff;
    assign resets       = resets_ff;
    assign irq          = irq_ff;
    assign boot_sel     = boot_sel_ff;
    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_n = ~drive_ff;

endmodule : srs_reset_sequencer

// ---- verification/srs_reset_sequencer_asserts.sv ----
// Port-level assertions for the system reset sequencer
`timescale 1ns/1ps
module srs_reset_sequencer_asserts (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Register bus
    input wire srs_pkg::srs_apb_req_t apb_req,
    input wire srs_pkg::srs_apb_rsp_t apb_rsp,
    // Supplies, pin, boot select, outputs
    input wire logic                  por_backup_n,
    input wire logic                  por_core_n,
    input wire logic                  rst_pin_i,
    input wire logic                  rst_pin_o,
    input wire logic                  rst_pin_oe_n,
    input wire logic                  boot_select_pin,
    input wire logic                  boot_sel,
    input wire srs_pkg::srs_resets_t  resets,
    input wire logic                  irq
);
    import srs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire setup  = apb_req.psel && !apb_req.penable;
    wire mapped = apb_req.paddr inside {REG_STATUS_OFF, REG_MODE_OFF, REG_MASK_OFF};
    wire rd_sts = apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite
                  && apb_req.paddr == REG_STATUS_OFF;

    a_pready_after_setup: assert property (setup |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (setup && !mapped
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_backup_drop_all: assert property (!por_backup_n
        |=> !resets.proc_rst_n && !resets.periph_rst_n && !resets.backup_rst_n && !rst_pin_oe_n)
        else $error("backup drop left a reset free");
    a_core_drop_keeps: assert property (resets.backup_rst_n && !por_core_n
        && por_backup_n |=> !resets.proc_rst_n && !resets.periph_rst_n && resets.backup_rst_n)
        else $error("core drop handled wrongly");
    a_release_together: assert property ($rose(resets.proc_rst_n)
        |-> resets.periph_rst_n && resets.backup_rst_n && resets.proc_clk_en)
        else $error("resets not released together");
    a_hold_clock: assert property ($rose(resets.proc_rst_n)
        |-> $past(resets.proc_clk_en, 3) && !$past(resets.proc_rst_n, 3))
        else $error("clock not enabled three cycles before release");
    a_pin_after_backup: assert property ($rose(resets.backup_rst_n)
        |-> !rst_pin_oe_n ##1 !rst_pin_oe_n ##1 rst_pin_oe_n)
        else $error("pin not freed two cycles after backup");
    a_boot_sample: assert property ($rose(por_core_n)
        |-> ##4 boot_sel == $past(boot_select_pin))
        else $error("boot select sampled at wrong cycle");
    a_irq_read_clear: assert property (rd_sts && rst_pin_i && $past(rst_pin_i)
        && $past(rst_pin_i, 2) && $past(rst_pin_i, 3) |-> ##2 !irq)
        else $error("status read did not clear irq");
endmodule : srs_reset_sequencer_asserts

// ---- verification/srs_pin_partner.sv ----
// Open-drain reset pin with pull-up and an external device holding it low
`timescale 1ns/1ps
module srs_pin_partner (
    // Clock
    input  wire logic clk,
    // Pin drivers
    input  wire logic rst_pin_o,
    input  wire logic rst_pin_oe_n,
    input  wire logic ext_low,
    // Wire level and last pulse driven by the block
    output logic      pin_level,
    output int        pulse_len
);
    int run_cnt = 0;
    // Pull-up unless either party pulls low
    assign pin_level = (rst_pin_oe_n | rst_pin_o) & ~ext_low;
    always @(posedge clk) begin
        if (!rst_pin_oe_n) begin
            run_cnt <= run_cnt + 1;
        end else if (run_cnt != 0) begin
            pulse_len <= run_cnt;
            run_cnt   <= 0;
        end
    end
endmodule : srs_pin_partner

// ---- verification/tb_srs_reset_sequencer.sv ----
// Testbench of the system reset sequencer over APB and the reset pin
`timescale 1ns/1ps
module tb_srs_reset_sequencer;
    import srs_pkg::*;
    logic         clk;
    logic         rst_n           = 1'b0;
    srs_apb_req_t apb_req         = '0;
    srs_apb_rsp_t apb_rsp;
    logic         por_backup_n    = 1'b1;
    logic         por_core_n      = 1'b1;
    logic         boot_select_pin = 1'b0;
    logic         ext_low         = 1'b0;
    logic         rst_pin_i, rst_pin_o, rst_pin_oe_n, boot_sel, irq;
    srs_resets_t  resets;
    logic [31:0]  rdat;
    logic         rerr;
    int           pulse_len, wn, pn, n_checks = 0, error_cnt = 0;

    srs_reset_sequencer u_srs_reset_sequencer (.clk(clk), .rst_n(rst_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .por_backup_n(por_backup_n), .por_core_n(por_core_n),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
        .boot_select_pin(boot_select_pin), .boot_sel(boot_sel), .resets(resets), .irq(irq));
    srs_pin_partner u_srs_pin_partner (.clk(clk), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_n(rst_pin_oe_n), .ext_low(ext_low), .pin_level(rst_pin_i),
        .pulse_len(pulse_len));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // One APB transfer; read data and error kept in rdat and rerr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            i++;
            if (i > 50) begin
                error_cnt++;
                $display("[ERR] %0t no pready", $time);
                report_and_stop();
            end
        end while (apb_rsp.pready !== 1'b1);
        rdat = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge clk);
    endtask : apb

    task automatic wait_proc(input logic lvl);
        wn = 0;
        while (resets.proc_rst_n !== lvl) begin
            @(posedge clk);
            wn++;
            if (wn > 600) begin
                error_cnt++;
                $display("[ERR] %0t processor reset wait timed out", $time);
                report_and_stop();
            end
        end
    endtask : wait_proc

    // Counts edges until the block stops pulling the pin low
    task automatic pin_free;
        pn = 0;
        while (rst_pin_oe_n !== 1'b1) begin
            @(posedge clk);
            pn++;
            if (pn > 100) begin
                error_cnt++;
                $display("[ERR] %0t pin release wait timed out", $time);
                report_and_stop();
            end
        end
    endtask : pin_free

    initial begin
        cyc(12);
        rst_n <= 1'b1;
        wait_proc(1'b1);
        pin_free();
        chk(32'(wn >= STARTUP_CYCLES), 32'h1);
        chk(resets, 4'hf);
        chk(pn, 32'h2);
        chk(rst_pin_o, 1'b0);
        cyc(8);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_TYPE_LSB +: TYPE_W], RST_TYPE_GENERAL);
        chk(rdat[STS_LEVEL_BIT], 1'b1);
        apb(1'b0, REG_MODE_OFF, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(rdat, 32'h0);
        $display("power-up test done");
        // Interrupt instead of reset
        apb(1'b1, REG_MODE_OFF, 32'h0000_0010);
        apb(1'b1, REG_MASK_OFF, 32'h0000_0001);
        ext_low <= 1'b1;
        cyc(4);
        ext_low <= 1'b0;
        cyc(8);
        chk({resets.proc_rst_n, irq}, 2'h3);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_SEEN_BIT], 1'b1);
        cyc(3);
        chk(irq, 1'b0);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_SEEN_BIT], 1'b0);
        apb(1'b1, REG_MASK_OFF, 32'h0);
        ext_low <= 1'b1;
        cyc(6);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_LEVEL_BIT], 1'b0);
        ext_low <= 1'b0;
        cyc(6);
        chk(irq, 1'b0);
        $display("pin interrupt test done");
        // Core supply drop with pulse length field 2, an 8-cycle pulse
        apb(1'b1, REG_MODE_OFF, 32'h0000_0200);
        boot_select_pin <= 1'b1;
        por_core_n      <= 1'b0;
        cyc(4);
        chk({resets.proc_rst_n, resets.backup_rst_n}, 2'h1);
        por_core_n <= 1'b1;
        wait_proc(1'b1);
        pin_free();
        chk(pn, 32'h8);
        cyc(12);
        chk(boot_sel, 1'b1);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_TYPE_LSB +: TYPE_W], RST_TYPE_WAKEUP);
        apb(1'b0, REG_MODE_OFF, 32'h0);
        chk(rdat, 32'h0000_0200);
        $display("core drop test done");
        // User reset held beyond the pulse
        apb(1'b1, REG_MODE_OFF, 32'h0000_0201);
        ext_low <= 1'b1;
        wait_proc(1'b0);
        cyc(25);
        chk({resets.proc_rst_n, resets.periph_rst_n}, 2'h0);
        chk(pulse_len, 32'h8);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_TYPE_LSB +: TYPE_W], RST_TYPE_WAKEUP);
        ext_low <= 1'b0;
        wait_proc(1'b1);
        cyc(4);
        apb(1'b0, REG_STATUS_OFF, 32'h0);
        chk(rdat[STS_TYPE_LSB +: TYPE_W], RST_TYPE_USER);
        $display("user reset test done");
        // Backup supply drop
        por_backup_n <= 1'b0;
        cyc(3);
        chk({resets[3:1], rst_pin_oe_n}, 4'h0);
        apb(1'b1, REG_MODE_OFF, 32'h0000_0201);
        por_backup_n <= 1'b1;
        wait_proc(1'b1);
        pin_free();
        chk(32'(wn >= STARTUP_CYCLES), 32'h1);
        chk(pn, 32'h2);
        cyc(4);
        apb(1'b0, REG_MODE_OFF, 32'h0);
        chk(rdat, 32'h0);
        $display("backup drop test done");
        report_and_stop();
    end
endmodule : tb_srs_reset_sequencer

bind srs_reset_sequencer srs_reset_sequencer_asserts u_srs_reset_sequencer_asserts (
    .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .por_backup_n(por_backup_n), .por_core_n(por_core_n), .rst_pin_i(rst_pin_i),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .boot_select_pin(boot_select_pin),
    .boot_sel(boot_sel), .resets(resets), .irq(irq));
